//--- core/adf_pkg.sv
// Constants and types shared by the decimation filter files
package adf_pkg;
    // --------------------------------------------------------------
    // Path select codes
    // --------------------------------------------------------------
    localparam logic [1:0] FILT_LL = 2'h0;
    localparam logic [1:0] FILT_WB_WIDE = 2'h1;
    localparam logic [1:0] FILT_WB_NARROW = 2'h2;
    localparam logic [1:0] FILT_RESERVED = 2'h3;
    // --------------------------------------------------------------
    // Widths and depths
    // --------------------------------------------------------------
    localparam int MOD_W = 4;
    localparam int C5_W = 29;
    localparam int ACC_W = 35;
    localparam int OUT_W = 24;
    localparam int FIR_W = 28;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_W = 7;
    // --------------------------------------------------------------
    // Decimation and settling counts
    // --------------------------------------------------------------
    localparam logic [4:0] SINC5_LAST = 5'h1F;
    localparam logic [11:0] SINC5_DEC = 12'h020;
    localparam logic [11:0] LL_SETTLE_32 = 12'h0A0;
    localparam logic [11:0] LL_SETTLE_128 = 12'h120;
    localparam logic [11:0] LL_SETTLE_512 = 12'h2A0;
    localparam logic [11:0] LL_SETTLE_2048 = 12'h8A0;
    localparam logic [6:0] WB_SETTLE_CONV = 7'h54;
    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef struct packed {
        logic [1:0] filter;
        logic [1:0] osr;
    } adf_sel_s;
    typedef enum {ST_IDLE, ST_SETTLE, ST_RUN} adf_state_e;
endpackage

//--- core/adf_decimation_filter.sv
// Decimation filter core with output word FIFO
//
// Functional notes
// (RULE_01) Three paths picked by two select pins
// (RULE_02) Four ratios; word rate is clock/ratio
// (RULE_03) First stage is sinc5 decimating by 32
// (RULE_04) Low-latency ratio 32 bypasses second stage
// (RULE_05) Second stage averages 4, 16 or 64
// (RULE_06) Wideband ratios are 32, 64, 128, 256
// (RULE_07) Narrow wideband path attenuates more strongly
// (RULE_08) Every path is linear phase
// (RULE_09) Controller changes selection only while stopped; code takes a pin change at any time and restarts the filter
// (RULE_10) Software issues stop then start after change
// (RULE_11) Controller discards conversion hit by change
// (RULE_12) Ready stays high until settled data exist
// (RULE_13) Frame-sync mode shifts zeros while settling
// (RULE_14) Low-latency settle: 160/288/672/2208 clocks
// (RULE_15) No output suppression after input steps
// (RULE_16) Wideband paths settle over 84 conversions
// (RULE_17) One modulator sample per master clock
// (RULE_18) Ratio pins decode ascending, 00 smallest
// (RULE_19) Filter pins: 00 LL, 01 wide, 10 narrow
`timescale 1ns/10ps
module adf_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [AW:0] used;

    assign used = wp - rp;
    assign in_ready = used != (AW+1)'(DEPTH);
    assign out_valid = wp != rp;
    assign out_data = mem[rp[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wp <= '0;
        end else if (in_valid && in_ready) begin
            wp <= wp + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rp <= '0;
        end else if (out_valid && out_ready) begin
            rp <= rp + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (in_valid && in_ready) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    fifo_bound_a: assert property (used <= (AW+1)'(DEPTH))
        else $error("fifo holds more than its depth");
endmodule // adf_fifo

module adf_decimation_filter (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic signed [adf_pkg::MOD_W-1:0] mod_sample,
    input wire logic [1:0] filter_select_pins,
    input wire logic [1:0] decimation_select_pins,
    input wire logic start_pin,
    input wire logic reset_powerdown_n_pin,
    input wire logic frame_sync_mode,
    output logic data_ready_n,
    output logic frame_sync_pulse,
    output logic word_accept,
    output logic out_valid,
    input wire logic out_ready,
    output logic [adf_pkg::OUT_W-1:0] out_data
);
    import adf_pkg::*;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic is_wb(input adf_sel_s s);
        return s.filter != FILT_LL;
    endfunction

    function automatic logic [2:0] stage2_shift(input adf_sel_s s);
        if (is_wb(s)) begin
            return {1'b0, s.osr}; // RULE_06
        end
        return {s.osr, 1'b0}; // RULE_05
    endfunction

    function automatic logic [11:0] ratio_of(input adf_sel_s s);
        return SINC5_DEC << stage2_shift(s); // RULE_02
    endfunction

    function automatic logic [11:0] ll_target(input logic [1:0] osr);
        case (osr) // RULE_14
            2'h0: return LL_SETTLE_32;
            2'h1: return LL_SETTLE_128;
            2'h2: return LL_SETTLE_512;
            default: return LL_SETTLE_2048;
        endcase
    endfunction

    // --------------------------------------------------------------
    // Pin synchronisers and selection
    // --------------------------------------------------------------
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    adf_sel_s sel_pin;
    adf_sel_s sel_q;
    logic run;
    logic run_q;
    logic fs_mode;
    logic clr;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {filter_select_pins, decimation_select_pins, start_pin,
                      reset_powerdown_n_pin, frame_sync_mode};
            sync2 <= sync1;
        end
    end

    always_comb begin
        sel_pin.filter = sync2[6:5];
        sel_pin.osr = sync2[4:3]; // RULE_18
        if (sync2[6:5] == FILT_RESERVED) begin
            sel_pin.filter = FILT_LL; // RULE_19 RULE_01
        end
    end

    assign run = sync2[2] & sync2[1];
    assign fs_mode = sync2[0];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sel_q <= '0;
            run_q <= 1'b0;
        end else begin
            sel_q <= sel_pin;
            run_q <= run;
        end
    end

    // Stop, power-down or a selection change restarts the filter
    assign clr = !run || (sel_pin != sel_q); // RULE_09

    // --------------------------------------------------------------
    // Sinc5 first stage
    // --------------------------------------------------------------
    logic signed [C5_W-1:0] integ [5];
    logic signed [C5_W-1:0] dly [5];
    logic signed [C5_W-1:0] comb_v [5];
    logic signed [C5_W-1:0] c5;
    logic [4:0] ph;
    logic c5_evt;

    always_ff @(posedge ref_clk) begin
        if (srst || clr) begin
            for (int k = 0; k < 5; k++) begin
                integ[k] <= '0;
            end
        end else begin
            integ[0] <= integ[0] + C5_W'(mod_sample); // RULE_17
            for (int k = 1; k < 5; k++) begin
                integ[k] <= integ[k] + integ[k-1];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || clr) begin
            ph <= '0;
        end else begin
            ph <= ph + 1'b1; // RULE_03
        end
    end

    always_comb begin
        comb_v[0] = integ[4] - dly[0];
        for (int k = 1; k < 5; k++) begin
            comb_v[k] = comb_v[k-1] - dly[k];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || clr) begin
            for (int k = 0; k < 5; k++) begin
                dly[k] <= '0;
            end
            c5 <= '0;
            c5_evt <= 1'b0;
        end else begin
            c5_evt <= ph == SINC5_LAST;
            if (ph == SINC5_LAST) begin
                dly[0] <= integ[4];
                for (int k = 1; k < 5; k++) begin
                    dly[k] <= comb_v[k-1];
                end
                c5 <= comb_v[4];
            end
        end
    end

    // --------------------------------------------------------------
    // Sinc1 second stage
    // --------------------------------------------------------------
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] sum_div;
    logic [5:0] n2;
    logic [5:0] n2_last;
    logic signed [OUT_W-1:0] avg;
    logic avg_evt;
    logic c5_keep;

    assign sum = acc + ACC_W'(c5); // RULE_05
    assign sum_div = sum >>> stage2_shift(sel_q);
    assign n2_last = 6'((7'h01 << stage2_shift(sel_q)) - 7'h01);

    always_ff @(posedge ref_clk) begin
        if (srst || clr) begin
            acc <= '0;
            n2 <= '0;
            avg <= '0;
            avg_evt <= 1'b0;
        end else begin
            avg_evt <= c5_keep && (n2 == n2_last);
            if (c5_keep) begin
                if (n2 == n2_last) begin
                    // Ratio 32 has n2_last 0: sinc5 word passes straight on
                    acc <= '0; // RULE_04
                    n2 <= '0;
                    avg <= sum_div[C5_W-1 -: OUT_W];
                end else begin
                    acc <= sum;
                    n2 <= n2 + 1'b1;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Symmetric FIR for the wideband paths
    // --------------------------------------------------------------
    logic signed [OUT_W-1:0] tap [5];
    logic signed [FIR_W-1:0] fir_wide;
    logic signed [FIR_W-1:0] fir_narrow;
    logic signed [OUT_W-1:0] y;
    logic word_evt;

    always_ff @(posedge ref_clk) begin
        if (srst || clr) begin
            for (int k = 0; k < 5; k++) begin
                tap[k] <= '0;
            end
            word_evt <= 1'b0;
        end else begin
            word_evt <= avg_evt;
            if (avg_evt) begin
                tap[0] <= avg;
                for (int k = 1; k < 5; k++) begin
                    tap[k] <= tap[k-1];
                end
            end
        end
    end

    // Even-symmetric taps keep constant group delay
    always_comb begin
        fir_wide = FIR_W'(tap[0]) + (FIR_W'(tap[1]) <<< 1) + FIR_W'(tap[2]); // RULE_08
        fir_narrow = FIR_W'(tap[0]) + (FIR_W'(tap[1]) <<< 2)
            + (FIR_W'(tap[2]) <<< 2) + (FIR_W'(tap[2]) <<< 1)
            + (FIR_W'(tap[3]) <<< 2) + FIR_W'(tap[4]); // RULE_07 RULE_08
        fir_wide = fir_wide >>> 2;
        fir_narrow = fir_narrow >>> 4;
        case (sel_q.filter)
            FILT_WB_WIDE: y = fir_wide[OUT_W-1:0];
            FILT_WB_NARROW: y = fir_narrow[OUT_W-1:0];
            default: y = tap[0];
        endcase
    end

    // --------------------------------------------------------------
    // Settling control
    // --------------------------------------------------------------
    adf_state_e state;
    logic [11:0] clk_cnt;
    logic [6:0] conv_cnt;
    logic settle_ok;

    // Low-latency ratios above 32 start averaging on the sinc5 word after the first settled one
    assign c5_keep = c5_evt && (is_wb(sel_q) || sel_q.osr == 2'h0 // RULE_14
                                || clk_cnt > LL_SETTLE_32);

    always_ff @(posedge ref_clk) begin
        if (srst || clr) begin
            clk_cnt <= '0;
        end else if (clk_cnt != ll_target(sel_q.osr)) begin
            clk_cnt <= clk_cnt + 1'b1; // RULE_14
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || clr) begin
            conv_cnt <= '0;
        end else if (word_evt && conv_cnt != WB_SETTLE_CONV) begin
            conv_cnt <= conv_cnt + 1'b1; // RULE_16
        end
    end

    assign settle_ok = is_wb(sel_q) ? (conv_cnt == WB_SETTLE_CONV)
                                    : (clk_cnt == ll_target(sel_q.osr));

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: state <= run ? ST_SETTLE : ST_IDLE;
                ST_SETTLE: state <= clr ? ST_IDLE : (settle_ok ? ST_RUN : ST_SETTLE);
                ST_RUN: state <= clr ? ST_IDLE : ST_RUN; // RULE_15
                default: state <= ST_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Output words, ready and frame pulse
    // --------------------------------------------------------------
    logic push;
    logic [OUT_W-1:0] push_data;

    assign push = word_evt && (settle_ok || fs_mode) && state != ST_IDLE;
    assign push_data = settle_ok ? y : '0; // RULE_13

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            data_ready_n <= 1'b1;
            frame_sync_pulse <= 1'b0;
        end else begin
            data_ready_n <= !(word_evt && settle_ok && !fs_mode); // RULE_12 RULE_15
            frame_sync_pulse <= word_evt && fs_mode;
        end
    end

    adf_fifo #(
        .W(OUT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .in_valid(push),
        .in_ready(word_accept),
        .in_data(push_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    logic [11:0] gap;
    logic seen;

    always_ff @(posedge ref_clk) begin
        if (srst || clr) begin
            gap <= '0;
            seen <= 1'b0;
        end else if (word_evt) begin
            gap <= 12'h001;
            seen <= 1'b1;
        end else if (gap != 12'hFFF) begin
            gap <= gap + 1'b1;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence start_seq;
        !run_q ##1 run_q;
    endsequence

    ll_rate_a: assert property (word_evt && seen && !is_wb(sel_q) // RULE_05
        |-> gap == ratio_of(sel_q))
        else $error("low-latency word spacing wrong");
    wb_rate_a: assert property (word_evt && seen && is_wb(sel_q) // RULE_06
        |-> gap == ratio_of(sel_q))
        else $error("wideband word spacing wrong");
    sinc5_step_a: assert property (disable iff (srst || clr) c5_evt |-> ##32 c5_evt) // RULE_03
        else $error("sinc5 stage not every 32 clocks");
    bypass_path_a: assert property (disable iff (srst || clr) // RULE_04
        !is_wb(sel_q) && sel_q.osr == 2'h0 && c5_evt |-> ##2 word_evt)
        else $error("ratio 32 does not bypass second stage");
    start_data_ready_n_a: assert property (start_seq |-> data_ready_n [*3]) // RULE_12
        else $error("ready asserted right after start");
    data_ready_n_hold_a: assert property (!settle_ok |=> data_ready_n) // RULE_12
        else $error("ready asserted before settling");
    zero_shift_a: assert property (push && !settle_ok |-> push_data == '0) // RULE_13
        else $error("unsettled word not zero");
    ll_settle_a: assert property ($rose(settle_ok) && !is_wb(sel_q) // RULE_14
        |-> clk_cnt == ll_target(sel_q.osr))
        else $error("low-latency settle count wrong");
    wb_settle_a: assert property ($rose(settle_ok) && is_wb(sel_q) // RULE_16
        |-> conv_cnt == WB_SETTLE_CONV)
        else $error("wideband settle count wrong");
    free_run_a: assert property (word_evt && settle_ok && !fs_mode |=> !data_ready_n) // RULE_15
        else $error("settled word suppressed");
    filt_decode_a: assert property (sync2[6:5] == FILT_RESERVED // RULE_19
        |=> sel_q.filter == FILT_LL)
        else $error("reserved filter code not mapped");
endmodule // adf_decimation_filter

//--- verif/adf_partner.sv
// Modulator sample source and output word consumer for the decimation filter
`timescale 1ns/10ps
module adf_partner (
    input wire logic ref_clk,
    input wire logic signed [adf_pkg::MOD_W-1:0] level,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [adf_pkg::OUT_W-1:0] out_data,
    output logic signed [adf_pkg::MOD_W-1:0] mod_sample,
    output logic out_ready,
    output logic [15:0] pop_count,
    output logic [adf_pkg::OUT_W-1:0] last_word
);
    import adf_pkg::*;
    initial begin
        mod_sample = '0;
        out_ready = 1'b0;
        pop_count = 16'h0000;
        last_word = '0;
    end
    // ----------------------------------------------------------------
    // Source: one sample each master clock
    // ----------------------------------------------------------------
    always @(negedge ref_clk) begin
        mod_sample <= level;
        out_ready <= !stall;
    end
    // ----------------------------------------------------------------
    // Consumer: keep the last popped word
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (out_valid === 1'b1 && out_ready) begin
            pop_count <= pop_count + 16'h0001;
            last_word <= out_data;
        end
    end
endmodule // adf_partner

//--- verif/test_adf_decimation_filter.sv
// Self-checking bench for the decimation filter
`timescale 1ns/10ps
module test_adf_decimation_filter;
    import adf_pkg::*;
    localparam logic [OUT_W-1:0] EXP_POS = 24'h200000;
    localparam logic [OUT_W-1:0] EXP_NEG = 24'hE00000;
    logic ref_clk, srst, start_pin, reset_powerdown_n_pin, frame_sync_mode, stall;
    logic [1:0] filter_select_pins, decimation_select_pins;
    logic signed [MOD_W-1:0] level, mod_sample;
    logic data_ready_n, frame_sync_pulse, word_accept, out_valid, out_ready;
    logic [OUT_W-1:0] out_data, last_word;
    logic [15:0] pop_count;
    logic ready_in_fs;
    int fails, comparisons;
    int tf[10] = '{0, 0, 0, 0, 3, 1, 1, 1, 1, 2};
    int to[10] = '{0, 1, 2, 3, 0, 0, 1, 2, 3, 0};
    int tp[10] = '{32, 128, 512, 2048, 32, 32, 64, 128, 256, 32};
    int ts[10] = '{160, 288, 672, 2208, 160, 2688, 5376, 10752, 21504, 2688};
    adf_decimation_filter u_dut (
        .ref_clk(ref_clk), .srst(srst), .mod_sample(mod_sample),
        .filter_select_pins(filter_select_pins),
        .decimation_select_pins(decimation_select_pins),
        .start_pin(start_pin), .reset_powerdown_n_pin(reset_powerdown_n_pin),
        .frame_sync_mode(frame_sync_mode), .data_ready_n(data_ready_n),
        .frame_sync_pulse(frame_sync_pulse), .word_accept(word_accept),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
    );
    adf_partner u_partner (
        .ref_clk(ref_clk), .level(level), .stall(stall), .out_valid(out_valid),
        .out_data(out_data), .mod_sample(mod_sample), .out_ready(out_ready),
        .pop_count(pop_count), .last_word(last_word)
    );
    // ----------------------------------------------------------------
    // Clock and monitors
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        if (frame_sync_mode === 1'b1 && data_ready_n !== 1'b1) ready_in_fs = 1'b1;
    end
    // ----------------------------------------------------------------
    // Report and compare tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (fails == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk_word(input string name, input logic [OUT_W-1:0] exp,
                            input logic [OUT_W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk_range(input string name, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            fails++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic wait_sig(input logic fs, input int limit, output int n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (n > limit) begin
                fails++;
                $display("[FAIL] pulse wait expected %0d cycles seen more", limit);
                finish_test();
            end
        end while (fs ? frame_sync_pulse !== 1'b1 : data_ready_n !== 1'b0);
    endtask
    task automatic restart(input logic [1:0] f, input logic [1:0] o, input logic fs,
                           input logic pd);
        int k;
        @(negedge ref_clk);
        if (pd) reset_powerdown_n_pin = 1'b0;
        else start_pin = 1'b0;
        filter_select_pins = f;
        decimation_select_pins = o;
        frame_sync_mode = fs;
        repeat (6) @(negedge ref_clk);
        // Words left from the stopped run are popped and ignored
        for (k = 0; k < 20 && out_valid === 1'b1; k++) @(negedge ref_clk);
        start_pin = 1'b1;
        reset_powerdown_n_pin = 1'b1;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int n, i, slack;
        logic [15:0] p;
        fails = 0;
        comparisons = 0;
        ready_in_fs = 1'b0;
        srst = 1'b1;
        start_pin = 1'b0;
        reset_powerdown_n_pin = 1'b1;
        frame_sync_mode = 1'b0;
        filter_select_pins = 2'h0;
        decimation_select_pins = 2'h0;
        level = 4'sh2;
        stall = 1'b0;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        chk_bit("data_ready_n idle", 1'b1, data_ready_n);
        chk_bit("frame_sync_pulse idle", 1'b0, frame_sync_pulse);
        chk_bit("out_valid idle", 1'b0, out_valid);
        chk_bit("word_accept idle", 1'b1, word_accept);
        // Low-latency and wide paths at every ratio, narrow at 32: settle time, word period, settled value
        for (i = 0; i < 10; i++) begin
            restart(2'(tf[i]), 2'(to[i]), 1'b0, i == 9);
            slack = (tf[i] == 1 || tf[i] == 2) ? 2 * tp[i] + 60 : 12;
            wait_sig(1'b0, ts[i] + slack, n);
            chk_range("first ready", ts[i], ts[i] + slack, n);
            wait_sig(1'b0, tp[i] + 2, n);
            chk_range("word period", tp[i], tp[i], n);
            repeat (3) @(negedge ref_clk);
            chk_word("settled word", EXP_POS, last_word);
        end
        // Input step while running: no word is withheld
        restart(2'h0, 2'h0, 1'b0, 1'b0);
        wait_sig(1'b0, 200, n);
        @(posedge ref_clk);
        level = -4'sh2;
        for (i = 0; i < 6; i++) begin
            wait_sig(1'b0, 40, n);
            chk_range("step period", 32, 32, n);
        end
        repeat (3) @(negedge ref_clk);
        chk_word("step word", EXP_NEG, last_word);
        // Fill the word buffer with the consumer stalled, then drain it
        @(posedge ref_clk);
        stall = 1'b1;
        repeat (320) @(negedge ref_clk);
        chk_bit("word_accept full", 1'b0, word_accept);
        chk_bit("out_valid full", 1'b1, out_valid);
        p = pop_count;
        @(posedge ref_clk);
        stall = 1'b0;
        for (i = 0; i < 30 && out_valid !== 1'b0; i++) @(negedge ref_clk);
        @(negedge ref_clk);
        chk_range("drained words", 8, 8, int'(pop_count - p));
        chk_bit("word_accept drained", 1'b1, word_accept);
        // Frame-sync mode: zeros until settled
        restart(2'h0, 2'h0, 1'b1, 1'b0);
        wait_sig(1'b1, 80, n);
        repeat (3) @(negedge ref_clk);
        chk_word("frame zero word", '0, last_word);
        for (i = 0; i < 8; i++) begin
            wait_sig(1'b1, 40, n);
        end
        repeat (3) @(negedge ref_clk);
        chk_word("frame settled word", EXP_NEG, last_word);
        chk_bit("ready in frame mode", 1'b0, ready_in_fs);
        finish_test();
    end
endmodule // test_adf_decimation_filter
